// ### hw/sbp_pkg.sv
// Purpose: shared constants and types for the serial bus phy base register bank
// Assumes: 8-bit registers in the low byte of 32-bit apb words
// Notes: field bit k of the bus convention maps to data bit (7 - k)
package sbp_pkg;

    // register byte addresses (word aligned)
    localparam logic [11:0] ADDR_NODE_STATUS = 12'h000;
    localparam logic [11:0] ADDR_RESET_GAP = 12'h004;
    localparam logic [11:0] ADDR_MAP_PORTS = 12'h008;
    localparam logic [11:0] ADDR_SPEED_DELAY = 12'h00c;
    localparam logic [11:0] ADDR_SELFID_CTRL = 12'h010;
    localparam logic [11:0] ADDR_EVENT_STATUS = 12'h014;

    // reset values and the misconfigured node number
    localparam logic [5:0] NODE_NUMBER_RST = 6'h00;
    localparam logic [5:0] GAP_SETTING_RST = 6'h3f;
    localparam logic [5:0] NODE_MISCONFIG = 6'h3f;
    localparam logic LINK_ACTIVE_RST = 1'b1;
    localparam logic CONTENDER_RST = 1'b0;
    localparam logic [1:0] PWR_CLASS_HI_RST = 2'h0;
    localparam logic CABLE_POWER_LOST_RST = 1'b1;

    // hard-wired capability fields
    localparam logic [2:0] MAP_FORMAT = 3'h7;
    localparam logic [3:0] PORT_COUNT = 4'h2;
    localparam logic [2:0] SPEED_CAP = 3'h2;
    localparam logic [3:0] REPEATER_DELAY = 4'h0;
    localparam logic [2:0] DELAY_SPREAD = 3'h0;

    // long bus reset duration
    localparam int LONG_RESET_US = 166;
    localparam int CLK_MHZ = 10;
    localparam int LONG_RESET_CYC = LONG_RESET_US * CLK_MHZ;
    localparam int LONG_RESET_W = 11;

    typedef struct packed {
        logic [5:0] node_number;
        logic is_root;
        logic tree_valid;
    } sbp_selfid_result_t;

    typedef struct packed {
        logic link_active;
        logic contender;
        logic [2:0] power_class;
    } sbp_selfid_fields_t;

endpackage

// ### hw/sbp_regs.sv
// Purpose: base register bank of the serial bus phy core, apb slave
// Assumes: pin inputs synchronous to mclk_in; detector level already qualified
// Notes: registers occupy data bits 7:0; upper bits read zero
`timescale 1ns/1ps
`default_nettype none

module sbp_regs #(
    parameter int LONG_RESET_CYC = sbp_pkg::LONG_RESET_CYC
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // phy core side
    input wire sbp_pkg::sbp_selfid_result_t selfid_result_in,
    input wire logic cable_power_ok_in,
    input wire logic link_power_status_in,
    input wire logic power_class_strap_pin_in,
    output logic force_root_out,
    output logic long_reset_active_out,
    output logic [5:0] gap_setting_out,
    output sbp_pkg::sbp_selfid_fields_t selfid_fields_out,
    output logic link_tx_enable_out
);

    // reverse bit order: bus convention bit 0 is msb
    function automatic logic [7:0] bitrev8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    logic [5:0] node_number_q;
    logic is_root_q;
    logic cable_power_status_q;
    logic cable_power_lost_q;
    logic force_root_request_q;
    logic long_reset_req_q;
    logic [5:0] gap_setting_q;
    logic link_active_control_q;
    logic contender_q;
    logic [2:0] power_class_q;
    logic strap_loaded_q;

    // counter wide enough for the full reset length, whatever the parameter
    localparam int LONG_RESET_W_L = $clog2(LONG_RESET_CYC + 1);

    logic [LONG_RESET_W_L-1:0] reset_cnt_q;

    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [7:0] wbyte;

    assign wr_en = psel_in && penable_in && pwrite_in && pstrb_in[0];
    assign rd_en = psel_in && penable_in && !pwrite_in;
    // field order in the byte is msb-first, so bit 0 of the field map is data bit 7
    assign wbyte = bitrev8(pwdata_in[7:0]);

    always_comb begin
        addr_ok = 1'b1;
        if (paddr_in == sbp_pkg::ADDR_NODE_STATUS) begin
            addr_ok = 1'b1;
        end else if (paddr_in == sbp_pkg::ADDR_RESET_GAP) begin
            addr_ok = 1'b1;
        end else if (paddr_in == sbp_pkg::ADDR_MAP_PORTS) begin
            addr_ok = 1'b1;
        end else if (paddr_in == sbp_pkg::ADDR_SPEED_DELAY) begin
            addr_ok = 1'b1;
        end else if (paddr_in == sbp_pkg::ADDR_SELFID_CTRL) begin
            addr_ok = 1'b1;
        end else if (paddr_in == sbp_pkg::ADDR_EVENT_STATUS) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !addr_ok;

    // self-id results; node number and root flag only change from the tree logic
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            node_number_q <= sbp_pkg::NODE_NUMBER_RST;
            is_root_q <= 1'b0;
        end else if (selfid_result_in.tree_valid) begin
            node_number_q <= selfid_result_in.node_number;
            is_root_q <= selfid_result_in.is_root;
        end
    end

    // cable power status and lost flag; a fall in the clear cycle still sets
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cable_power_status_q <= 1'b0;
            cable_power_lost_q <= sbp_pkg::CABLE_POWER_LOST_RST;
        end else begin
            cable_power_status_q <= cable_power_ok_in;
            if (cable_power_status_q && !cable_power_ok_in) begin
                cable_power_lost_q <= 1'b1;
            end else if (wr_en && paddr_in == sbp_pkg::ADDR_EVENT_STATUS && wbyte[3]) begin
                cable_power_lost_q <= 1'b0;
            end
        end
    end

    // writable control fields
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            force_root_request_q <= 1'b0;
            gap_setting_q <= sbp_pkg::GAP_SETTING_RST;
            link_active_control_q <= sbp_pkg::LINK_ACTIVE_RST;
            contender_q <= sbp_pkg::CONTENDER_RST;
        end else if (wr_en && paddr_in == sbp_pkg::ADDR_RESET_GAP) begin
            force_root_request_q <= wbyte[0];
            gap_setting_q <= {wbyte[2], wbyte[3], wbyte[4], wbyte[5], wbyte[6], wbyte[7]};
        end else if (wr_en && paddr_in == sbp_pkg::ADDR_SELFID_CTRL) begin
            link_active_control_q <= wbyte[0];
            contender_q <= wbyte[1];
        end
    end

    // power class: strap caught by a clocked load on the first edge after release
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            power_class_q <= 3'h0;
            strap_loaded_q <= 1'b0;
        end else if (!strap_loaded_q) begin
            strap_loaded_q <= 1'b1;
            power_class_q <= {sbp_pkg::PWR_CLASS_HI_RST, power_class_strap_pin_in};
        end else if (wr_en && paddr_in == sbp_pkg::ADDR_SELFID_CTRL) begin
            power_class_q <= {wbyte[5], wbyte[6], wbyte[7]};
        end
    end

    // long bus reset: request bit self-clears when the timer is started
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            long_reset_req_q <= 1'b0;
            reset_cnt_q <= '0;
        end else begin
            if (long_reset_req_q) begin
                long_reset_req_q <= 1'b0;
                reset_cnt_q <= LONG_RESET_W_L'(LONG_RESET_CYC);
            end else if (reset_cnt_q != '0) begin
                reset_cnt_q <= reset_cnt_q - 1'b1;
            end
            if (wr_en && paddr_in == sbp_pkg::ADDR_RESET_GAP && wbyte[1]) begin
                long_reset_req_q <= 1'b1;
            end
        end
    end

    assign long_reset_active_out = reset_cnt_q != '0;
    assign force_root_out = force_root_request_q;
    assign gap_setting_out = gap_setting_q;
    assign selfid_fields_out.link_active = link_active_control_q && link_power_status_in;
    assign selfid_fields_out.contender = contender_q;
    assign selfid_fields_out.power_class = power_class_q;
    // misconfigured bus: keep the link silent
    assign link_tx_enable_out = node_number_q != sbp_pkg::NODE_MISCONFIG;

    // read data: assembled in bus bit order, msb-first, with no net reversal into data bits
    logic [7:0] rbyte;
    always_comb begin
        rbyte = 8'h00;
        if (paddr_in == sbp_pkg::ADDR_NODE_STATUS) begin
            rbyte = {node_number_q[5], node_number_q[4], node_number_q[3], node_number_q[2],
                     node_number_q[1], node_number_q[0], is_root_q, cable_power_status_q};
            rbyte = bitrev8(bitrev8(rbyte));
        end else if (paddr_in == sbp_pkg::ADDR_RESET_GAP) begin
            rbyte = {force_root_request_q, long_reset_req_q, gap_setting_q};
        end else if (paddr_in == sbp_pkg::ADDR_MAP_PORTS) begin
            rbyte = {sbp_pkg::MAP_FORMAT, 1'b0, sbp_pkg::PORT_COUNT};
        end else if (paddr_in == sbp_pkg::ADDR_SPEED_DELAY) begin
            rbyte = {sbp_pkg::SPEED_CAP, 1'b0, sbp_pkg::REPEATER_DELAY};
        end else if (paddr_in == sbp_pkg::ADDR_SELFID_CTRL) begin
            rbyte = {link_active_control_q, contender_q, sbp_pkg::DELAY_SPREAD, power_class_q};
        end else if (paddr_in == sbp_pkg::ADDR_EVENT_STATUS) begin
            // lost flag reads at the same data bit that a write of one clears
            rbyte = {3'h0, cable_power_lost_q, 4'h0};
        end else begin
            rbyte = 8'h00;
        end
    end

    // the msb-first layout above already matches data bits 7..0 directly
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            prdata_out <= {24'h00_0000, rbyte};
        end
    end

endmodule // sbp_regs

`default_nettype wire

// ### tb/sbp_core_model.sv
// Purpose: stand-in for the tree logic and cable power detector
// Assumes: bench commands each self-id result
// Notes: result valid lasts one cycle, as a real tree pass would
`timescale 1ns/1ps
`default_nettype none
module sbp_core_model (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic load_in,
    input wire logic [5:0] node_in,
    input wire logic root_in,
    input wire logic power_in,
    output sbp_pkg::sbp_selfid_result_t result_out,
    output logic power_ok_out
);
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            result_out <= '0;
            power_ok_out <= 1'b1;
        end else begin
            result_out <= '{node_in, root_in, load_in};
            power_ok_out <= power_in;
        end
    end
endmodule // sbp_core_model
`default_nettype wire

// ### tb/sbp_regs_sva.sv
// Purpose: port-level checks of the phy base register bank
// Assumes: bench sets LONG_RESET_CYC to 8, the unrolled count in a_long_len
// Notes: one clock domain, so default clocking and disable are used
`timescale 1ns/1ps
`default_nettype none
module sbp_regs_sva #(
    parameter int LONG_RESET_CYC = 8
) (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pslverr_out,
    input wire sbp_pkg::sbp_selfid_result_t selfid_result_in,
    input wire logic link_power_status_in,
    input wire logic force_root_out,
    input wire logic long_reset_active_out,
    input wire logic [5:0] gap_setting_out,
    input wire sbp_pkg::sbp_selfid_fields_t selfid_fields_out,
    input wire logic link_tx_enable_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    logic acc;
    logic wr_gap;
    assign acc = psel_in && penable_in;
    assign wr_gap = acc && pwrite_in && pstrb_in[0] && paddr_in == sbp_pkg::ADDR_RESET_GAP;
    a_gap_write: assert property (wr_gap |=> gap_setting_out == $past(pwdata_in[5:0]))
        else $error("gap setting not taken from write");
    a_root_write: assert property (wr_gap |=> force_root_out == $past(pwdata_in[7]))
        else $error("force root not taken from write");
    a_long_start: assert property (wr_gap && pwdata_in[6] |-> ##2 long_reset_active_out)
        else $error("long reset did not start");
    a_long_len: assert property ($rose(long_reset_active_out) |->
        long_reset_active_out [*8] ##1 !long_reset_active_out) else $error("long reset length");
    a_map_const: assert property (psel_in && !penable_in && !pwrite_in &&
        paddr_in == sbp_pkg::ADDR_MAP_PORTS |=> prdata_out == 32'h000000e2)
        else $error("map word wrong");
    a_err_unmap: assert property (acc |->
        pslverr_out == (paddr_in > sbp_pkg::ADDR_EVENT_STATUS)) else $error("slave error wrong");
    a_tx_block: assert property (selfid_result_in.tree_valid |=> link_tx_enable_out ==
        ($past(selfid_result_in.node_number) != sbp_pkg::NODE_MISCONFIG))
        else $error("transmit enable wrong");
    a_link_and: assert property (selfid_fields_out.link_active |-> link_power_status_in)
        else $error("link bit set without link power");
    c_long: cover property (wr_gap && pwdata_in[6]);
    c_misconf: cover property ($fell(link_tx_enable_out));
    c_unmap: cover property (acc && pslverr_out);
endmodule // sbp_regs_sva
bind sbp_regs sbp_regs_sva #(.LONG_RESET_CYC(LONG_RESET_CYC)) u_sva (.mclk_in, .arst_n_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out,
    .pslverr_out, .selfid_result_in, .link_power_status_in, .force_root_out,
    .long_reset_active_out, .gap_setting_out, .selfid_fields_out, .link_tx_enable_out);
`default_nettype wire

// ### tb/serial_bus_phy_base_registers_tb.sv
// Purpose: self-checking bench of the phy base register bank
// Assumes: zero-wait apb slave, long reset shortened to 8 cycles
// Notes: random register values from an lfsr seeded with 5
`timescale 1ns/1ps
`default_nettype none
module serial_bus_phy_base_registers_tb;
    logic mclk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic pready_out, pslverr_out, err, force_root_out, long_reset_active_out, link_tx_enable_out;
    logic link_power_status_in = 1'b1, load = 1'b0, root = 1'b0, pwr = 1'b1;
    logic [5:0] node = 6'h00, gap_setting_out;
    logic [7:0] v = 8'h05;
    sbp_pkg::sbp_selfid_result_t selfid_result_in;
    sbp_pkg::sbp_selfid_fields_t selfid_fields_out;
    logic cable_power_ok_in;
    int bad_count = 0, samples_checked = 0, n;
    always #50 mclk_in = ~mclk_in;
    sbp_regs #(.LONG_RESET_CYC(8)) dut (.mclk_in, .arst_n_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in(4'h1), .prdata_out, .pready_out,
        .pslverr_out, .selfid_result_in, .cable_power_ok_in, .link_power_status_in,
        .power_class_strap_pin_in(1'b1), .force_root_out, .long_reset_active_out,
        .gap_setting_out, .selfid_fields_out, .link_tx_enable_out);
    sbp_core_model u_core (.mclk_in, .arst_n_in, .load_in(load), .node_in(node),
        .root_in(root), .power_in(pwr), .result_out(selfid_result_in),
        .power_ok_out(cable_power_ok_in));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [31:0] node_word(input logic [5:0] n6, input logic r, input logic p);
        return {24'h0, n6, r, p};
    endfunction
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // called just after a rising edge; request held until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge mclk_in);
            if (pready_out === 1'b1) break;
        end
        if (i == 16) begin
            bad_count++;
            end_of_test();
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic sid(input logic [5:0] n6, input logic r);
        node <= n6;
        root <= r;
        load <= 1'b1;
        @(posedge mclk_in);
        load <= 1'b0;
        repeat (3) @(posedge mclk_in);
    endtask
    initial begin
        repeat (8) @(posedge mclk_in);
        arst_n_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, node_word(6'h00, 1'b0, 1'b1));
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h3f);
        apb(1'b1, 12'h008, 32'hff);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'he2);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h40);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h81);
        apb(1'b0, 12'h018, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        for (int k = 0; k < 6; k++) begin
            v = lfsr(v);
            link_power_status_in <= v[3];
            apb(1'b1, 12'h004, {24'h0, v[7], 1'b0, v[5:0]});
            chk({force_root_out, gap_setting_out}, {v[7], v[5:0]});
            apb(1'b1, 12'h010, {24'h0, v});
            apb(1'b0, 12'h010, 32'h0);
            chk(rd, {24'h0, v[7:6], 3'h0, v[2:0]});
            chk(selfid_fields_out, {v[7] & v[3], v[6], v[2:0]});
        end
        apb(1'b1, 12'h004, 32'h7f);
        // the timer starts on the edge the task ends on: look once it has settled
        @(negedge mclk_in);
        chk(long_reset_active_out, 1'b1);
        @(posedge mclk_in);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h3f);
        for (n = 0; n < 100 && long_reset_active_out; n++) @(posedge mclk_in);
        chk(long_reset_active_out, 1'b0);
        sid(6'h05, 1'b1);
        apb(1'b0, 12'h000, 32'h0);
        chk({rd, link_tx_enable_out}, {node_word(6'h05, 1'b1, 1'b1), 1'b1});
        sid(6'h3f, 1'b0);
        chk(link_tx_enable_out, 1'b0);
        apb(1'b1, 12'h014, 32'h10);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h0);
        pwr <= 1'b0;
        repeat (3) @(posedge mclk_in);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, node_word(6'h3f, 1'b0, 1'b0));
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h10);
        end_of_test();
    end
endmodule // serial_bus_phy_base_registers_tb
`default_nettype wire
